// file: src/apm_map.svh
`ifndef APM_MAP_SVH
`define APM_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define APM_ADDR_INACT_THRESH 6'h25
`define APM_ADDR_INACT_TIME 6'h26
`define APM_ADDR_RATE_SEL 6'h2C
`define APM_ADDR_POWER_CONTROL 6'h2D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define APM_PC_MEASURE 3
`define APM_PC_AUTO_SLEEP 4
`define APM_PC_LINK 5
`define APM_RS_LOW_POWER 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define APM_RST_POWER_CONTROL 8'h00
`define APM_RST_RATE_SEL 8'h0A
`define APM_RST_INACT 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APM_CLK_HZ 20000000
`define APM_TOP_ODR_HZ 3200
`define APM_TOP_ODR_DIV (`APM_CLK_HZ / `APM_TOP_ODR_HZ)
`define APM_TOP_RATE_CODE 4'hF
`define APM_SLEEP_RATE_CODE 4'h6

`endif

// file: src/apm_pkg.sv
package apm_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_STANDBY,
		MODE_MEASURE,
		MODE_SLEEP
	} apm_mode_e;

	typedef struct packed
	{
		logic measuring;
		logic sleeping;
		logic low_power;
		logic fifo_hold;
	} apm_status_s;

endpackage : apm_pkg

// file: src/apm_rate_tick.sv
`include "apm_map.svh"

// sampling and output-rate tick generator
module apm_rate_tick #(
	parameter int TOP_DIV = `APM_TOP_ODR_DIV
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic enable,
	input wire logic [3:0] rate,
	input wire logic low_power,
	output logic odr_tick,
	output logic sample_tick
);

	// longest period, base shifted by 15, must fit the 28-bit counter
	if (TOP_DIV < 2 || TOP_DIV % 2 != 0 || TOP_DIV > 16382)
	begin : g_bad_div
		$error("TOP_DIV must be even, 2 to 16382");
	end

	// half of the output period in clocks: doubles per step down from the top rate
	function automatic logic [27:0] half_period(input logic [3:0] code);
		logic [27:0] base;
		base = 28'(TOP_DIV / 2);
		return base << (`APM_TOP_RATE_CODE - code);
	endfunction : half_period

	logic [27:0] cnt;
	logic phase;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	// normal mode samples twice per output period, low power once
	always_ff @(posedge clk)
	begin
		if (reset || !enable)
		begin
			cnt <= '0;
			phase <= 1'b0;
			odr_tick <= 1'b0;
			sample_tick <= 1'b0;
		end
		else if (cnt >= half_period(rate) - 28'h0000_001)
		begin
			cnt <= '0;
			phase <= !phase;
			odr_tick <= phase;
			sample_tick <= !low_power || phase;
		end
		else
		begin
			cnt <= cnt + 28'h0000_001;
			odr_tick <= 1'b0;
			sample_tick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_lowpower_halves: assert property (@(posedge clk) disable iff (reset)
		(sample_tick && $past(low_power)) |-> odr_tick)
		else $error("low power sample away from output tick");

	a_odr_period_end: assert property (@(posedge clk) disable iff (reset)
		odr_tick |-> ($past(cnt) >= half_period($past(rate)) - 28'h0000_001))
		else $error("output tick before the period ended");

endmodule : apm_rate_tick

// file: src/apm_power_ctrl.sv
`include "apm_map.svh"

// Summary of operation
// - after power-up the block sits in standby with all sensing stopped
// - measure bit 3 of power control enters measurement, clearing returns standby
// - every register is writable and readable in standby
// - no sampling takes place while in standby
// - entering standby keeps the sample buffer contents untouched
// - low power bit 4 of rate select halves internal sampling
// - 4-bit rate code picks output rate, 1111 fastest, halving per step
// - with auto sleep and link set, inactivity drops to a slow sleep rate
module apm_power_ctrl #(
	parameter int TOP_DIV = `APM_TOP_ODR_DIV,
	parameter int CYCLES_PER_SEC = `APM_CLK_HZ
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [7:0] sample_mag,
	output logic odr_tick,
	output logic sample_tick,
	output logic [3:0] active_rate,
	output apm_pkg::apm_status_s status
);

	// the one-second counter is 25 bits wide
	if (CYCLES_PER_SEC < 2 || CYCLES_PER_SEC > 33554431)
	begin : g_bad_sec
		$error("CYCLES_PER_SEC out of range");
	end

	logic [7:0] inactivity_threshold;
	logic [7:0] inactivity_time;
	logic [7:0] rate_and_sampling_select;
	logic [7:0] power_control;
	apm_pkg::apm_mode_e mode;
	apm_pkg::apm_mode_e next_mode;
	logic [24:0] sec_cnt;
	logic sec_tick;
	logic [7:0] idle_secs;
	logic sleep_en;
	logic active_seen;
	logic inactive;

	// register read decode, unmapped offsets read zero
	function automatic logic [7:0] read_mux(input logic [5:0] addr);
		if (addr == `APM_ADDR_INACT_THRESH)
			return inactivity_threshold;
		else if (addr == `APM_ADDR_INACT_TIME)
			return inactivity_time;
		else if (addr == `APM_ADDR_RATE_SEL)
			return rate_and_sampling_select;
		else if (addr == `APM_ADDR_POWER_CONTROL)
			return power_control;
		else
			return 8'h00;
	endfunction : read_mux

	// sleep uses the slower of the sleep rate and the programmed rate
	function automatic logic [3:0] pick_rate(input apm_pkg::apm_mode_e m, input logic [3:0] prog);
		if (m == apm_pkg::MODE_SLEEP && prog > `APM_SLEEP_RATE_CODE)
			return `APM_SLEEP_RATE_CODE;
		else
			return prog;
	endfunction : pick_rate

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// writes accepted in every mode, standby included
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			inactivity_threshold <= `APM_RST_INACT;
			inactivity_time <= `APM_RST_INACT;
			rate_and_sampling_select <= `APM_RST_RATE_SEL;
			power_control <= `APM_RST_POWER_CONTROL;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `APM_ADDR_INACT_THRESH)
				inactivity_threshold <= reg_wdata;
			else if (reg_addr == `APM_ADDR_INACT_TIME)
				inactivity_time <= reg_wdata;
			else if (reg_addr == `APM_ADDR_RATE_SEL)
				rate_and_sampling_select <= reg_wdata;
			else if (reg_addr == `APM_ADDR_POWER_CONTROL)
				power_control <= reg_wdata;
		end
	end

	// read data, held until the next read
	always_ff @(posedge clk)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= read_mux(reg_addr);
	end

	// ----------------------------------------------------------------
	// inactivity detection
	// ----------------------------------------------------------------
	assign sleep_en = power_control[`APM_PC_AUTO_SLEEP] && power_control[`APM_PC_LINK];
	assign active_seen = sample_valid && (sample_mag > inactivity_threshold);
	assign inactive = (inactivity_time != 8'h00) && (idle_secs >= inactivity_time);

	// one-second enable while measuring
	always_ff @(posedge clk)
	begin
		if (reset || mode != apm_pkg::MODE_MEASURE || sec_tick)
			sec_cnt <= '0;
		else
			sec_cnt <= sec_cnt + 25'h000_0001;
	end
	assign sec_tick = (sec_cnt == 25'(CYCLES_PER_SEC - 1));

	// whole seconds without a sample above threshold
	always_ff @(posedge clk)
	begin
		if (reset || mode != apm_pkg::MODE_MEASURE || active_seen)
			idle_secs <= 8'h00;
		else if (sec_tick && idle_secs != 8'hFF)
			idle_secs <= idle_secs + 8'h01;
	end

	// ----------------------------------------------------------------
	// mode state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_mode = mode;
		case (mode)
			apm_pkg::MODE_STANDBY:
				if (power_control[`APM_PC_MEASURE])
					next_mode = apm_pkg::MODE_MEASURE;
			apm_pkg::MODE_MEASURE:
				if (!power_control[`APM_PC_MEASURE])
					next_mode = apm_pkg::MODE_STANDBY;
				else if (sleep_en && inactive)
					next_mode = apm_pkg::MODE_SLEEP;
			apm_pkg::MODE_SLEEP:
				if (!power_control[`APM_PC_MEASURE])
					next_mode = apm_pkg::MODE_STANDBY;
				else if (!sleep_en || active_seen)
					next_mode = apm_pkg::MODE_MEASURE;
			default:
				next_mode = apm_pkg::MODE_STANDBY;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			mode <= apm_pkg::MODE_STANDBY;
		else
			mode <= next_mode;
	end

	// status and rate follow the mode being entered
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			status <= '{measuring: 1'b0, sleeping: 1'b0, low_power: 1'b0, fifo_hold: 1'b1};
			active_rate <= 4'(`APM_RST_RATE_SEL);
		end
		else
		begin
			status.measuring <= (next_mode == apm_pkg::MODE_MEASURE);
			status.sleeping <= (next_mode == apm_pkg::MODE_SLEEP);
			status.low_power <= rate_and_sampling_select[`APM_RS_LOW_POWER];
			// buffer frozen, never flushed, in standby
			status.fifo_hold <= (next_mode == apm_pkg::MODE_STANDBY);
			active_rate <= pick_rate(next_mode, rate_and_sampling_select[3:0]);
		end
	end

	// ----------------------------------------------------------------
	// rate generator
	// ----------------------------------------------------------------
	// stopped in standby so no sampling happens
	apm_rate_tick #(
		.TOP_DIV(TOP_DIV)
	) u_rate_tick (
		.clk(clk),
		.reset(reset),
		.enable(status.measuring || status.sleeping),
		.rate(active_rate),
		.low_power(status.low_power),
		.odr_tick(odr_tick),
		.sample_tick(sample_tick)
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_reset_standby: assert property (@(posedge clk)
		reset |=> (!status.measuring && !status.sleeping && status.fifo_hold))
		else $error("not in standby after reset");

	a_measure_enter: assert property (@(posedge clk) disable iff (reset)
		(mode == apm_pkg::MODE_STANDBY && power_control[`APM_PC_MEASURE]) |=> status.measuring)
		else $error("measure bit did not start measurement");

	a_measure_leave: assert property (@(posedge clk) disable iff (reset)
		!power_control[`APM_PC_MEASURE] |=> (!status.measuring && !status.sleeping))
		else $error("cleared measure bit did not return standby");

	a_reg_write: assert property (@(posedge clk) disable iff (reset)
		(reg_wr && reg_addr == `APM_ADDR_INACT_TIME) |=> inactivity_time == $past(reg_wdata))
		else $error("register write lost");

	a_reg_read: assert property (@(posedge clk) disable iff (reset)
		(reg_rd && reg_addr == `APM_ADDR_POWER_CONTROL) |=> reg_rdata == $past(power_control))
		else $error("register read wrong");

	a_standby_quiet: assert property (@(posedge clk) disable iff (reset)
		($past(status.fifo_hold) && status.fifo_hold) |-> (!sample_tick && !odr_tick))
		else $error("sampling during standby");

	a_fifo_kept: assert property (@(posedge clk) disable iff (reset)
		(mode == apm_pkg::MODE_STANDBY) |-> status.fifo_hold)
		else $error("buffer not held in standby");

	a_sleep_entry: assert property (@(posedge clk) disable iff (reset)
		(mode == apm_pkg::MODE_MEASURE && power_control[`APM_PC_MEASURE] && sleep_en && inactive)
		|=> (status.sleeping && active_rate <= `APM_SLEEP_RATE_CODE))
		else $error("inactivity did not enter sleep");

	a_wake_rate: assert property (@(posedge clk) disable iff (reset)
		(mode == apm_pkg::MODE_SLEEP && power_control[`APM_PC_MEASURE] && active_seen)
		|=> (status.measuring && active_rate == $past(rate_and_sampling_select[3:0])))
		else $error("activity did not restore programmed rate");

	c_enter_measure: cover property (@(posedge clk) disable iff (reset)
		mode == apm_pkg::MODE_STANDBY ##1 mode == apm_pkg::MODE_MEASURE);

	c_enter_sleep: cover property (@(posedge clk) disable iff (reset)
		mode == apm_pkg::MODE_MEASURE ##1 mode == apm_pkg::MODE_SLEEP);

	c_wake: cover property (@(posedge clk) disable iff (reset)
		mode == apm_pkg::MODE_SLEEP ##1 mode == apm_pkg::MODE_MEASURE);

endmodule : apm_power_ctrl

// file: testbench/apm_host_model.sv
`include "apm_map.svh"

// host side of the register port, strobes change at the falling edge
module apm_host_model (
	input wire logic clk,
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle port at time zero
	initial
	begin
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one write strobe, then address and data scrambled
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : write_reg

	// one read strobe, data taken a cycle later
	task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge clk);
		d = reg_rdata;
	endtask : read_reg

	// settings first, power control always last
	task automatic configure(input logic [7:0] th, tm, rt, pc);
		write_reg(`APM_ADDR_INACT_THRESH, th);
		write_reg(`APM_ADDR_INACT_TIME, tm);
		write_reg(`APM_ADDR_RATE_SEL, rt);
		write_reg(`APM_ADDR_POWER_CONTROL, pc);
	endtask : configure

endmodule : apm_host_model

// file: testbench/accel_power_mode_control_tb_top.sv
`include "apm_map.svh"

`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) \
		begin \
			fails++; \
			$display("wrong value %s expected %h seen %h", nm, ex, got); \
		end \
	end

module accel_power_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk;
	logic reset;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic sample_valid;
	logic [7:0] sample_mag;
	logic odr_tick;
	logic sample_tick;
	logic [3:0] active_rate;
	apm_pkg::apm_status_s status;
	logic [7:0] rd;
	logic [5:0] ad [5] = '{6'h25, 6'h26, 6'h2C, 6'h2D, 6'h30};
	logic [7:0] dv [5] = '{8'h00, 8'h00, 8'h0A, 8'h00, 8'h00};
	int fails;
	int checks_done;
	int n_odr;
	int n_smp;
	int c;
	int lp;

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	apm_power_ctrl #(.TOP_DIV(8), .CYCLES_PER_SEC(20)) i_dut (
		.clk(clk),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.sample_valid(sample_valid),
		.sample_mag(sample_mag),
		.odr_tick(odr_tick),
		.sample_tick(sample_tick),
		.active_rate(active_rate),
		.status(status)
	);

	apm_host_model i_host (
		.clk(clk),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// counts both ticks over a window of cycles
	task automatic count_ticks(input int cyc);
		n_odr = 0;
		n_smp = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			#1;
			n_odr += odr_tick;
			n_smp += sample_tick;
		end
	endtask : count_ticks

	// bounded wait for one status bit
	task automatic wait_st(input int b, input logic v);
		int i;
		for (i = 0; i < 100 && status[b] !== v; i++)
			@(negedge clk);
		if (i == 100)
		begin
			fails++;
			print_verdict();
		end
	endtask : wait_st

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		sample_valid = 1'b0;
		sample_mag = 8'h00;
		fails = 0;
		checks_done = 0;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		`CHK("status", 4'b0001, status);
		`CHK("rate", 4'hA, active_rate);
		count_ticks(64);
		`CHK("standby ticks", 0, n_odr + n_smp);
		// defaults, write and read back, unmapped place last
		for (int k = 0; k < 5; k++)
		begin
			i_host.read_reg(ad[k], rd);
			`CHK("reset value", dv[k], rd);
			i_host.write_reg(ad[k], 8'h57);
			i_host.read_reg(ad[k], rd);
			`CHK("read back", (k == 4) ? 8'h00 : 8'h57, rd);
		end
		`CHK("still standby", 1'b0, status.measuring);
		// rate sweep, low power only at code 1100
		i_host.configure(8'hFF, 8'h00, 8'h0F, 8'h08);
		wait_st(3, 1'b1);
		`CHK("fifo hold", 1'b0, status.fifo_hold);
		for (int k = 0; k < 5; k++)
		begin
			c = (k < 4) ? 15 - k : 12;
			lp = (k == 4);
			i_host.write_reg(`APM_ADDR_RATE_SEL, {3'b000, lp[0], c[3:0]});
			count_ticks(140);
			count_ticks(256);
			`CHK("odr ticks", 32 >> (15 - c), n_odr);
			`CHK("sample ticks", (64 >> (15 - c)) >> lp, n_smp);
			`CHK("low power", lp[0], status.low_power);
			`CHK("active rate", c[3:0], active_rate);
		end
		// back to standby keeps the buffer
		i_host.write_reg(`APM_ADDR_POWER_CONTROL, 8'h00);
		wait_st(3, 1'b0);
		`CHK("fifo hold", 1'b1, status.fifo_hold);
		count_ticks(64);
		`CHK("standby ticks", 0, n_odr + n_smp);
		// auto sleep alone does nothing, with link it sleeps
		i_host.configure(8'h40, 8'h01, 8'h0A, 8'h18);
		count_ticks(60);
		`CHK("no sleep", 1'b0, status.sleeping);
		i_host.write_reg(`APM_ADDR_POWER_CONTROL, 8'h38);
		wait_st(2, 1'b1);
		`CHK("sleep rate", 4'h6, active_rate);
		@(negedge clk);
		sample_valid = 1'b1;
		sample_mag = 8'h80;
		@(negedge clk);
		sample_valid = 1'b0;
		sample_mag = 8'h00;
		wait_st(2, 1'b0);
		@(negedge clk);
		`CHK("awake", 1'b1, status.measuring);
		`CHK("rate back", 4'hA, active_rate);
		print_verdict();
	end

endmodule : accel_power_mode_control_tb_top
